// [core/irq_enable_ctrl.sv]
// Enable, priority, edge and master enable logic of the interrupt controller
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Port A pin gets level from high/low enable bit pair, 00 off.
// RULE2: Port C pins use the same two-bit level encoding per bit.
// RULE3: Port A pair has eight bits; bit 6 governs the shared source.
// RULE4: Port C enables exist in low nibble only; upper bits stay zero.
// RULE5: Edge bit 0 requests on falling edge, 1 on rising edge.
// RULE6: Shared select bit 6 picks pin 6 when 0, comparator when 1.
// RULE7: Software disables the shared request before changing its source.
// RULE8: Control bit 7 is master enable; bits 6 to 0 read zero.
// RULE9: Master enable set by enable, return instruction or write of one.
// RULE10: Master enable cleared by disable, core acknowledge, reset, write zero.
// RULE11: Requests set pending bits; forwarded only while master enable set.
// RULE12: Highest pending enabled level goes first; lower index wins ties.
module irq_enable_ctrl (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] port_a_pin_input,
   input wire logic [3:0] port_c_pin_input,
   input wire logic comparator_out,
   input wire logic enable_interrupts_instruction,
   input wire logic disable_interrupts_instruction,
   input wire logic interrupt_return_instruction,
   input wire logic cpu_irq_ack,
   output irq_ctrl_pkg::irq_req_t irq_o
);
   irq_ctrl_pkg::bus_state_t bus_state_r;
   irq_ctrl_pkg::bus_state_t bus_state_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic [11:0] pend_r;
   logic [11:0] pend_nxt;
   logic [11:0] en_high_r;
   logic [11:0] en_high_nxt;
   logic [11:0] en_low_r;
   logic [11:0] en_low_nxt;
   logic [7:0] edge_polarity_r;
   logic [7:0] edge_polarity_nxt;
   logic pin6_comparator_choice_r;
   logic pin6_comparator_choice_nxt;
   logic gie_r;
   logic gie_nxt;
   irq_ctrl_pkg::irq_req_t irq_r;
   irq_ctrl_pkg::irq_req_t irq_nxt;
   logic [11:0] src_sig;
   logic [11:0] rise_sel;
   logic [11:0] req;
   logic [11:0] idx;
   logic sel_ok;
   logic bus_req;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] rbyte;

   // Decode: word index in address bits 13:2, low byte lane carries data
   assign idx = wb_adr_i[13:2];
   assign sel_ok = (wb_adr_i[15:14] == 2'b00);
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wbyte = wb_dat_i[7:0];
   // Write lands on the acking edge, when the master sees ack
   assign wr_en = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0] & sel_ok;

   // Source routing; pin 6 is shared with the comparator
   always_comb begin
      src_sig = {port_c_pin_input, port_a_pin_input};
      // A source switch can itself look like an edge; see RULE7
      src_sig[irq_ctrl_pkg::SHARED_PIN] = pin6_comparator_choice_r ?
         comparator_out : port_a_pin_input[irq_ctrl_pkg::SHARED_PIN]; // see RULE6
      // Port C pins reuse the low four polarity bits
      rise_sel = {edge_polarity_r[3:0], edge_polarity_r}; // see RULE5
   end

   edge_req u_edge (
      .clk(clk),
      .srst(srst),
      .sig_in(src_sig),
      .rise_sel(rise_sel),
      .req(req)
   );

   // Bus slave: ack one cycle after request, dropped the cycle after
   always_comb begin
      bus_state_nxt = irq_ctrl_pkg::BUS_IDLE;
      case (bus_state_r)
         irq_ctrl_pkg::BUS_IDLE: begin
            if (bus_req) begin
               bus_state_nxt = irq_ctrl_pkg::BUS_ACK;
            end
         end
         irq_ctrl_pkg::BUS_ACK: begin
            bus_state_nxt = irq_ctrl_pkg::BUS_IDLE;
         end
         default: begin
            bus_state_nxt = irq_ctrl_pkg::BUS_IDLE;
         end
      endcase
   end
   assign wb_ack_o = (bus_state_r == irq_ctrl_pkg::BUS_ACK);

   // Read mux; reserved and unmapped bits read as zero
   always_comb begin
      rbyte = 8'h00;
      if (sel_ok) begin
         case (idx)
            irq_ctrl_pkg::IDX_PA_PEND: rbyte = pend_r[7:0];
            irq_ctrl_pkg::IDX_PA_ENH: rbyte = en_high_r[7:0]; // see RULE3
            irq_ctrl_pkg::IDX_PA_ENL: rbyte = en_low_r[7:0]; // see RULE3
            irq_ctrl_pkg::IDX_PC_PEND: rbyte = {4'h0, pend_r[11:8]};
            irq_ctrl_pkg::IDX_PC_ENH: rbyte = {4'h0, en_high_r[11:8]}; // see RULE4
            irq_ctrl_pkg::IDX_PC_ENL: rbyte = {4'h0, en_low_r[11:8]}; // see RULE4
            irq_ctrl_pkg::IDX_EDGE: rbyte = edge_polarity_r;
            irq_ctrl_pkg::IDX_SHARED: rbyte = {1'b0, pin6_comparator_choice_r,
               6'h00};
            irq_ctrl_pkg::IDX_CTL: rbyte = {gie_r, 7'h00}; // see RULE8
            default: rbyte = 8'h00;
         endcase
      end
   end

   // Read data captured in the request cycle, held through ack
   always_comb begin
      dat_nxt = dat_r;
      if (bus_req && !wb_ack_o) begin
         dat_nxt = {24'h000000, rbyte};
      end
   end
   assign wb_dat_o = dat_r;

   // Configuration registers
   always_comb begin
      en_high_nxt = en_high_r;
      en_low_nxt = en_low_r;
      edge_polarity_nxt = edge_polarity_r;
      pin6_comparator_choice_nxt = pin6_comparator_choice_r;
      if (wr_en) begin
         case (idx)
            irq_ctrl_pkg::IDX_PA_ENH: en_high_nxt[7:0] = wbyte; // see RULE3
            irq_ctrl_pkg::IDX_PA_ENL: en_low_nxt[7:0] = wbyte; // see RULE3
            // Upper nibble has no storage, so it stays zero; see RULE4
            irq_ctrl_pkg::IDX_PC_ENH: en_high_nxt[11:8] = wbyte[3:0];
            irq_ctrl_pkg::IDX_PC_ENL: en_low_nxt[11:8] = wbyte[3:0];
            irq_ctrl_pkg::IDX_EDGE: edge_polarity_nxt = wbyte; // see RULE5
            irq_ctrl_pkg::IDX_SHARED: pin6_comparator_choice_nxt =
               wbyte[irq_ctrl_pkg::PIN6_SEL_BIT]; // see RULE6
            default: begin
            end
         endcase
      end
   end

   // Pending bits: software writes, ack clears, a new request wins
   always_comb begin
      pend_nxt = pend_r;
      if (wr_en && idx == irq_ctrl_pkg::IDX_PA_PEND) begin
         pend_nxt[7:0] = wbyte;
      end
      if (wr_en && idx == irq_ctrl_pkg::IDX_PC_PEND) begin
         pend_nxt[11:8] = wbyte[3:0];
      end
      if (cpu_irq_ack && irq_r.valid) begin
         pend_nxt[irq_r.source] = 1'b0;
      end
      pend_nxt = pend_nxt | req; // see RULE11
   end

   // Master enable; a set in the same cycle as a clear wins
   always_comb begin
      gie_nxt = gie_r;
      if (disable_interrupts_instruction || cpu_irq_ack) begin
         gie_nxt = 1'b0; // see RULE10
      end
      if (wr_en && idx == irq_ctrl_pkg::IDX_CTL) begin
         gie_nxt = wbyte[irq_ctrl_pkg::GIE_BIT]; // see RULE9
      end
      if (enable_interrupts_instruction || interrupt_return_instruction) begin
         gie_nxt = 1'b1; // see RULE9
      end
   end

   // Priority pick: strict compare keeps the lowest index on a tie
   always_comb begin
      logic [1:0] lvl;
      lvl = irq_ctrl_pkg::LVL_OFF;
      irq_nxt = '0;
      for (int i = 0; i < irq_ctrl_pkg::NUM_SRC; i++) begin
         lvl = {en_high_r[i], en_low_r[i]}; // see RULE1, see RULE2
         if (pend_r[i] && lvl > irq_nxt.level) begin // see RULE12
            irq_nxt.level = lvl;
            irq_nxt.source = 4'(i);
         end
      end
      // Held off while disabled or while the core is acknowledging
      irq_nxt.valid = gie_r && !cpu_irq_ack &&
         irq_nxt.level != irq_ctrl_pkg::LVL_OFF; // see RULE11
   end
   assign irq_o = irq_r;

   // State registers
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_state_r <= irq_ctrl_pkg::BUS_IDLE;
         dat_r <= 32'h00000000;
         pend_r <= irq_ctrl_pkg::RST_SRC;
         en_high_r <= irq_ctrl_pkg::RST_SRC;
         en_low_r <= irq_ctrl_pkg::RST_SRC;
         edge_polarity_r <= irq_ctrl_pkg::RST_BYTE;
         pin6_comparator_choice_r <= irq_ctrl_pkg::RST_BIT;
         gie_r <= irq_ctrl_pkg::RST_BIT; // see RULE10
         irq_r <= '0;
      end else begin
         bus_state_r <= bus_state_nxt;
         dat_r <= dat_nxt;
         pend_r <= pend_nxt;
         en_high_r <= en_high_nxt;
         en_low_r <= en_low_nxt;
         edge_polarity_r <= edge_polarity_nxt;
         pin6_comparator_choice_r <= pin6_comparator_choice_nxt;
         gie_r <= gie_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   gie_set_a: // see RULE9
   assert property (enable_interrupts_instruction ||
      interrupt_return_instruction |=> gie_r)
      else $error("master enable not set by instruction");

   gie_clear_a: // see RULE10
   assert property ((disable_interrupts_instruction || cpu_irq_ack) &&
      !enable_interrupts_instruction && !interrupt_return_instruction &&
      !(wr_en && idx == irq_ctrl_pkg::IDX_CTL) |=> !gie_r)
      else $error("master enable not cleared");

   irq_gated_a: // see RULE11
   assert property (irq_o.valid |-> $past(gie_r))
      else $error("request forwarded while disabled");

   pend_set_a: // see RULE11
   assert property (req[3] |=> pend_r[3])
      else $error("pending bit not set by request");

   ctl_read_a: // see RULE8
   assert property (bus_req && !wb_we_i && !wb_ack_o && sel_ok &&
      idx == irq_ctrl_pkg::IDX_CTL |=> wb_dat_o[6:0] == 7'h00 &&
      wb_dat_o[7] == $past(gie_r))
      else $error("control register read wrong");

   pc_upper_a: // see RULE4
   assert property (bus_req && !wb_we_i && !wb_ack_o && sel_ok &&
      idx == irq_ctrl_pkg::IDX_PC_ENH |=> wb_dat_o[7:4] == 4'h0)
      else $error("port C enable upper bits not zero");

   bus_ack_a:
   assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle after request");

   level_code_a: // see RULE1
   assert property (irq_o.valid |-> irq_o.level ==
      $past({en_high_r[irq_nxt.source], en_low_r[irq_nxt.source]}))
      else $error("forwarded level does not match enable pair");

   prio_win_a: // see RULE12
   assert property (irq_o.valid && $past(pend_r[0]) &&
      $past({en_high_r[0], en_low_r[0]}) == irq_ctrl_pkg::LVL_HIGH |->
      irq_o.source == 4'h0)
      else $error("highest level source 0 not chosen");

   shared_route_a: // see RULE6
   assert property (pin6_comparator_choice_r &&
      $past(pin6_comparator_choice_r) &&
      (edge_polarity_r[irq_ctrl_pkg::SHARED_PIN] ?
      $rose(comparator_out) : $fell(comparator_out)) |=>
      pend_r[irq_ctrl_pkg::SHARED_PIN])
      else $error("comparator edge not routed to shared request");

   // Register stores: each write lands on the acking edge
   enh_store_a: // see RULE3
   assert property (wr_en && idx == irq_ctrl_pkg::IDX_PA_ENH |=>
      en_high_r[7:0] == $past(wbyte))
      else $error("port A enable high write lost");

   enl_store_a: // see RULE3
   assert property (wr_en && idx == irq_ctrl_pkg::IDX_PA_ENL |=>
      en_low_r[7:0] == $past(wbyte))
      else $error("port A enable low write lost");

   pc_store_a: // see RULE2
   assert property (wr_en && idx == irq_ctrl_pkg::IDX_PC_ENL |=>
      en_low_r[11:8] == $past(wbyte[3:0]))
      else $error("port C enable low write lost");

   edge_store_a: // see RULE5
   assert property (wr_en && idx == irq_ctrl_pkg::IDX_EDGE |=>
      edge_polarity_r == $past(wbyte))
      else $error("edge polarity write lost");

   shared_store_a: // see RULE6
   assert property (wr_en && idx == irq_ctrl_pkg::IDX_SHARED |=>
      pin6_comparator_choice_r ==
      $past(wbyte[irq_ctrl_pkg::PIN6_SEL_BIT]))
      else $error("shared source select write lost");

   // Direct write of the master enable, unless an instruction sets it
   gie_write_a: // see RULE9
   assert property (wr_en && idx == irq_ctrl_pkg::IDX_CTL &&
      !enable_interrupts_instruction && !interrupt_return_instruction |=>
      gie_r == $past(wbyte[irq_ctrl_pkg::GIE_BIT]))
      else $error("master enable write lost");

   // Writes with the low byte lane off are dropped
   lane_ignore_a:
   assert property (bus_req && wb_we_i && wb_ack_o && !wb_sel_i[0] |=>
      $stable(edge_polarity_r))
      else $error("write without low byte lane took effect");

   // Core acceptance withdraws the request from the next cycle
   ack_drop_a: // see RULE10
   assert property (cpu_irq_ack |=> !irq_o.valid)
      else $error("request still forwarded after acknowledge");

   fwd_pending_a: // see RULE11
   assert property (irq_o.valid |-> $past(pend_r[irq_nxt.source]))
      else $error("forwarded source was not pending");

   fwd_level_a: // see RULE1
   assert property (irq_o.valid |-> irq_o.level != irq_ctrl_pkg::LVL_OFF)
      else $error("disabled source forwarded");

   idle_ack_a:
   assert property (!bus_req |=> !wb_ack_o)
      else $error("ack without a bus request");

   prio_tie_a: // see RULE12
   assert property (irq_o.valid && $past(pend_r[1]) &&
      $past({en_high_r[1], en_low_r[1]}) == irq_o.level |->
      irq_o.source <= 4'h1)
      else $error("tie not resolved to the lower source");
endmodule // irq_enable_ctrl

// [core/irq_ctrl_pkg.sv]
// Constants, offsets and carrier types of the interrupt enable controller
package irq_ctrl_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [11:0] IDX_PA_PEND = 12'hfc3;
   localparam logic [11:0] IDX_PA_ENH = 12'hfc4;
   localparam logic [11:0] IDX_PA_ENL = 12'hfc5;
   localparam logic [11:0] IDX_PC_PEND = 12'hfc6;
   localparam logic [11:0] IDX_PC_ENH = 12'hfc7;
   localparam logic [11:0] IDX_PC_ENL = 12'hfc8;
   localparam logic [11:0] IDX_EDGE = 12'hfcd;
   localparam logic [11:0] IDX_SHARED = 12'hfce;
   localparam logic [11:0] IDX_CTL = 12'hfcf;
   // Field positions
   localparam int GIE_BIT = 7;
   localparam int PIN6_SEL_BIT = 6;
   localparam int SHARED_PIN = 6;
   // Source counts: port A pins first, then port C pins
   localparam int NUM_A = 8;
   localparam int NUM_C = 4;
   localparam int NUM_SRC = 12;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [11:0] RST_SRC = 12'h000;
   localparam logic RST_BIT = 1'b0;
   // Two-bit enable and priority encoding
   typedef enum logic [1:0] {
      LVL_OFF = 2'b00,
      LVL_LOW = 2'b01,
      LVL_NOM = 2'b10,
      LVL_HIGH = 2'b11
   } prio_level_t;
   // Bus slave states, Gray coded
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK = 2'b01
   } bus_state_t;
   // Request presented to the core
   typedef struct packed {
      logic valid;
      logic [1:0] level;
      logic [3:0] source;
   } irq_req_t;
endpackage

// [core/edge_req.sv]
// Per-source edge detector with selectable polarity
`timescale 1ns/1ps
module edge_req (
   input wire logic clk,
   input wire logic srst,
   input wire logic [11:0] sig_in,
   input wire logic [11:0] rise_sel,
   output logic [11:0] req
);
   logic [11:0] prev_r;
   logic [11:0] prev_nxt;
   logic primed_r;
   logic primed_nxt;

   // Previous sample; primed blocks a false edge right after reset
   always_comb begin
      prev_nxt = sig_in;
      primed_nxt = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prev_r <= irq_ctrl_pkg::RST_SRC;
         primed_r <= irq_ctrl_pkg::RST_BIT;
      end else begin
         prev_r <= prev_nxt;
         primed_r <= primed_nxt;
      end
   end

   // One detector per source
   genvar g;
   generate
      for (g = 0; g < irq_ctrl_pkg::NUM_SRC; g++) begin : g_det
         assign req[g] = primed_r & (rise_sel[g] ? // see RULE5
            (sig_in[g] & ~prev_r[g]) : (~sig_in[g] & prev_r[g]));
      end
   endgenerate

   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   rise_edge_a: // see RULE5
   assert property (primed_r && rise_sel[0] && $rose(sig_in[0]) |-> req[0])
      else $error("rising edge on source 0 not detected");
   fall_edge_a: // see RULE5
   assert property (primed_r && !rise_sel[0] && $fell(sig_in[0]) |-> req[0])
      else $error("falling edge on source 0 not detected");
endmodule // edge_req

// [test/core_ack_model.sv]
// Processor core stand-in that accepts presented requests
`timescale 1ns/1ps
module core_ack_model (
   input wire logic clk,
   input wire logic srst,
   input wire irq_ctrl_pkg::irq_req_t irq,
   input wire logic ack_en,
   input wire logic [2:0] ack_delay,
   output logic cpu_irq_ack
);
   logic [2:0] cnt_r;
   logic hold_r;
   // Accept after a chosen wait; skip the cycle where valid is still old
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= 3'h0;
         hold_r <= 1'b0;
         cpu_irq_ack <= 1'b0;
      end else begin
         cpu_irq_ack <= 1'b0;
         hold_r <= cpu_irq_ack;
         if (!irq.valid || !ack_en || hold_r || cpu_irq_ack) begin
            cnt_r <= 3'h0;
         end else if (cnt_r == ack_delay) begin
            cpu_irq_ack <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end
endmodule // core_ack_model

// [test/irq_enable_ctrl_tb.sv]
// Self-checking bench with a register and request model
`timescale 1ns/1ps
module irq_enable_ctrl_tb;
   localparam logic [7:0] MSK [13] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'h0f,
      8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h40, 8'h80};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [3:0] lane = 4'hf;
   logic [15:0] adr = 16'h0000;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o;
   logic ack;
   logic [7:0] pa = 8'h00;
   logic [3:0] pc = 4'h0;
   logic cmp = 1'b0;
   logic [2:0] ins_r = 3'h0;
   logic cpu_ack;
   logic ack_en = 1'b0;
   logic [2:0] dly = 3'h0;
   irq_ctrl_pkg::irq_req_t irq;
   logic [7:0] rg [13];
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int n;

   always #25 clk = ~clk;

   irq_enable_ctrl dut_u (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .port_a_pin_input(pa), .port_c_pin_input(pc), .comparator_out(cmp),
      .enable_interrupts_instruction(ins_r[0]),
      .interrupt_return_instruction(ins_r[1]),
      .disable_interrupts_instruction(ins_r[2]),
      .cpu_irq_ack(cpu_ack), .irq_o(irq));

   core_ack_model core_u (.clk(clk), .srst(srst), .irq(irq),
      .ack_en(ack_en), .ack_delay(dly), .cpu_irq_ack(cpu_ack));

   // Expected request: highest level first, lowest source on ties
   function automatic irq_ctrl_pkg::irq_req_t exp_irq();
      irq_ctrl_pkg::irq_req_t e;
      logic [11:0] p;
      logic [11:0] h;
      logic [11:0] lo;
      e = '0;
      p = {rg[3][3:0], rg[0]};
      h = {rg[4][3:0], rg[1]};
      lo = {rg[5][3:0], rg[2]};
      for (int i = 0; i < 12; i++) begin
         if (p[i] && {h[i], lo[i]} > e.level) begin
            e.level = {h[i], lo[i]};
            e.source = 4'(i);
         end
      end
      e.valid = rg[12][7] && e.level != 2'b00;
      return e;
   endfunction

   task automatic cmp_reg(input logic [11:0] a, input logic [7:0] e,
         input logic [31:0] g);
      n_compared++;
      if (g !== {24'h0, e}) begin
         n_errors++;
         $display("FAIL reg %h expected %h seen %h", a, e, g);
      end
   endtask

   task automatic cmp_irq();
      irq_ctrl_pkg::irq_req_t e;
      e = exp_irq();
      n_compared++;
      if (irq.valid !== e.valid || (e.valid && irq !== e)) begin
         n_errors++;
         $display("FAIL irq expected %h seen %h", e, irq);
      end
   endtask

   // One classic cycle; held until ack is sampled, then released
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lane;
      adr <= {2'b00, a, 2'b00};
      dat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      if (!w) cmp_reg(a, rg[a - 12'hfc3], dat_o);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      rg[a - 12'hfc3] = d & MSK[a - 12'hfc3];
   endtask

   task automatic rd_all();
      for (int k = 0; k < 13; k++) bus(1'b0, 12'hfc3 + 12'(k), 8'h00);
   endtask

   // Instruction pulse: 0 enable, 1 return, 2 disable
   task automatic ins(input int k);
      @(posedge clk);
      ins_r[k] <= 1'b1;
      @(posedge clk);
      ins_r[k] <= 1'b0;
      rg[12][7] = k != 2;
      bus(1'b0, 12'hfcf, 8'h00);
      cmp_irq();
   endtask

   // Flip one source; 12 is the comparator, seen only when selected
   task automatic tog(input int s);
      logic nv;
      logic [3:0] d;
      @(posedge clk);
      nv = s < 8 ? !pa[s] : s < 12 ? !pc[s-8] : !cmp;
      d = s < 12 ? 4'(s) : 4'h6;
      if (s < 8) pa[s] <= nv;
      else if (s < 12) pc[s-8] <= nv;
      else cmp <= nv;
      if ((d != 6 || rg[11][6] == (s == 12)) && nv == rg[10][d[2:0]]) begin
         if (d[3]) rg[3][d[1:0]] = 1'b1;
         else rg[0][d[2:0]] = 1'b1;
      end
      repeat (3) @(posedge clk);
      cmp_irq();
   endtask

   // Core accepts; pending bit and master enable drop
   task automatic take();
      irq_ctrl_pkg::irq_req_t e;
      e = exp_irq();
      if (!e.valid) return;
      ack_en <= 1'b1;
      dly <= 3'($urandom);
      do @(posedge clk); while (cpu_ack !== 1'b1);
      ack_en <= 1'b0;
      if (e.source[3]) rg[3][e.source[1:0]] = 1'b0;
      else rg[0][e.source[2:0]] = 1'b0;
      rg[12][7] = 1'b0;
      repeat (2) @(posedge clk);
      cmp_irq();
      bus(1'b0, 12'hfc3, 8'h00);
      bus(1'b0, 12'hfc6, 8'h00);
   endtask

   // Switching the shared source may itself raise a request
   task automatic shsel();
      logic [7:0] h;
      logic [7:0] l;
      logic ov;
      h = rg[1];
      l = rg[2];
      ov = rg[11][6] ? cmp : pa[6];
      wr(12'hfc4, h & 8'hbf);
      wr(12'hfc5, l & 8'hbf);
      wr(12'hfce, rg[11] ^ 8'h40);
      if ((rg[11][6] ? cmp : pa[6]) != ov && rg[10][6] == !ov)
         rg[0][6] = 1'b1;
      repeat (3) @(posedge clk);
      wr(12'hfc4, h);
      wr(12'hfc5, l);
      bus(1'b0, 12'hfc3, 8'h00);
   endtask

   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         final_report();
      end
   end

   // Main sequence
   initial begin
      rg = '{default: 8'h00};
      void'($urandom(32'h423b0609));
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd_all();
      wr(12'hfcf, 8'hff);
      bus(1'b0, 12'hfcf, 8'h00);
      wr(12'hfcf, 8'h00);
      wr(12'hfc4, 8'hcc);
      wr(12'hfc5, 8'haa);
      wr(12'hfc7, 8'h0c);
      wr(12'hfc8, 8'h0a);
      // Low byte lane off: the write is acked but must not land
      lane = 4'he;
      bus(1'b1, 12'hfcd, 8'hff);
      lane = 4'hf;
      bus(1'b0, 12'hfcd, 8'h00);
      wr(12'hfcd, 8'($urandom));
      rd_all();
      ins(0);
      for (n = 0; n < 60; n++) begin
         tog($urandom % 13);
         if ($urandom % 2) take();
         ins($urandom % 3);
         if (n % 20 == 9) shsel();
         if (n % 16 == 5) wr(12'hfc3, 8'($urandom));
      end
      rd_all();
      final_report();
   end
endmodule // irq_enable_ctrl_tb
